// ### hw/rrr_maint.sv
/*
  Device-side sequencer for targeted row refresh and post-package repair,
  with an AHB-Lite register slave.
  Assumes decoded DRAM commands arrive one per cycle, synchronous to hclk.
*/
// The implementer's own choices: register access over AHB-Lite and the register addresses.
// Overview of operation
// - Unlimited tolerance makes targeted refresh optional; enable response is configurable.
// - Mode bit 7 enables targeted refresh; bits 6 to 4 pick the bank.
// - Mode clears itself after third bank precharge plus precharge time and mode-write delay.
// - Optional exit write clears enable; the bank field is then ignored.
// - Three activates and three precharges complete it; precharge-all counts.
// - Repair is optional, one row per bank, irreversible (fused_reg here clears on hresetn); guard against accidental entry.
`timescale 1ns/100ps
`default_nettype none
module rrr_maint #(
  parameter int unsigned PGM_CYCLES = rrr_pkg::PGM_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cmd_valid,
  input wire rrr_pkg::rrr_cmd_t cmd_op,
  input wire logic [2:0] cmd_bank,
  input wire logic cmd_all,
  input wire logic [5:0] cmd_ma,
  input wire logic [7:0] cmd_data,
  output logic trr_active,
  output logic [2:0] trr_bank,
  output logic repair_programming,
  output logic [7:0] fused_banks
);
  import rrr_pkg::*;

  initial begin
    if (PGM_CYCLES < 1 || PGM_CYCLES >= (1 << 25)) $error("PGM_CYCLES out of range");
    if (TRP_CYC + MRD_CYC > 255) $error("Done wait too long for timer");
  end

  function automatic logic bank_hit(input logic [2:0] b, input logic all, input logic [2:0] sel);
    return all || (b == sel);
  endfunction : bank_hit

  // ==========================================================
  // Command decode
  wire logic any_cmd = cmd_valid && (cmd_op != CMD_DES);
  wire logic is_act = cmd_valid && (cmd_op == CMD_ACT);
  wire logic is_pre = cmd_valid && (cmd_op == CMD_PRE);
  wire logic is_mrw = cmd_valid && (cmd_op == CMD_MRW);
  wire logic mrw_trr = is_mrw && (cmd_ma == MA_REFRESH_REPAIR);
  wire logic mrw_ppr = is_mrw && (cmd_ma == MA_STATUS_REPAIR);
  wire logic trr_set = mrw_trr && cmd_data[TRR_EN_BIT];
  wire logic trr_clr = mrw_trr && !cmd_data[TRR_EN_BIT];

  logic [15:0] cfg_reg;
  logic [FLAG_W-1:0] flags_reg, flags_next, flag_set;
  wire logic unlimited = (cfg_reg[2:0] == LIMIT_UNLIMITED) && cfg_reg[CFG_UNLIM_BIT];
  wire logic unlim_ignore = unlimited && cfg_reg[CFG_IGNORE_BIT];
  wire logic [7:0] support = cfg_reg[CFG_SUPPORT_LSB +: 8];

  // ==========================================================
  // Targeted row refresh
  rrr_trr_t trr_state, trr_state_next;
  logic [1:0] act_cnt_reg, act_cnt_next, pre_cnt_reg, pre_cnt_next;
  logic [7:0] trr_tmr_reg, trr_tmr_next;
  logic [2:0] trr_bank_reg, trr_bank_next;
  logic trr_en_reg, trr_en_next;
  wire logic act_hit = is_act && bank_hit(cmd_bank, 1'b0, trr_bank_reg);
  wire logic pre_hit = is_pre && bank_hit(cmd_bank, cmd_all, trr_bank_reg);
  wire logic pre_counts = pre_hit && (pre_cnt_reg < act_cnt_reg);
  wire logic third_pre = pre_counts && (pre_cnt_reg == 2'(TRR_OPS - 1));

  always_comb begin
    trr_state_next = trr_state;
    act_cnt_next = act_cnt_reg;
    pre_cnt_next = pre_cnt_reg;
    trr_tmr_next = trr_tmr_reg;
    trr_bank_next = trr_bank_reg;
    trr_en_next = trr_en_reg;
    case (trr_state)
      TRR_IDLE: begin
        if (trr_set && !unlim_ignore) begin
          trr_state_next = TRR_ENTRY;
          trr_bank_next = cmd_data[TRR_BANK_LSB +: 3];
          trr_en_next = 1'b1;
          trr_tmr_next = 8'(MRD_CYC - 1);
          act_cnt_next = 2'h0;
          pre_cnt_next = 2'h0;
        end
      end
      TRR_ENTRY: begin
        if (trr_tmr_reg == 8'h00) begin
          trr_state_next = TRR_ACTIVE;
        end else begin
          trr_tmr_next = trr_tmr_reg - 8'h01;
        end
      end
      TRR_ACTIVE: begin
        if (act_hit && act_cnt_reg != 2'(TRR_OPS)) begin
          act_cnt_next = act_cnt_reg + 2'h1;
        end
        if (pre_counts) begin
          pre_cnt_next = pre_cnt_reg + 2'h1;
        end
        if (third_pre) begin
          trr_state_next = TRR_DONE;
          trr_tmr_next = 8'(TRP_CYC + MRD_CYC - 1);
        end
      end
      TRR_DONE: begin
        if (trr_tmr_reg == 8'h00) begin
          trr_state_next = TRR_IDLE;
          trr_en_next = 1'b0;
        end else begin
          trr_tmr_next = trr_tmr_reg - 8'h01;
        end
      end
      default: trr_state_next = TRR_IDLE;
    endcase
    // Clearing write aborts or exits; bank field ignored either way
    if (trr_clr) begin
      trr_state_next = TRR_IDLE;
      trr_en_next = 1'b0;
      trr_bank_next = trr_bank_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trr_state <= TRR_IDLE;
      act_cnt_reg <= 2'h0;
      pre_cnt_reg <= 2'h0;
      trr_tmr_reg <= 8'h00;
      trr_bank_reg <= 3'h0;
      trr_en_reg <= 1'b0;
    end else begin
      trr_state <= trr_state_next;
      act_cnt_reg <= act_cnt_next;
      pre_cnt_reg <= pre_cnt_next;
      trr_tmr_reg <= trr_tmr_next;
      trr_bank_reg <= trr_bank_next;
      trr_en_reg <= trr_en_next;
    end
  end

  // ==========================================================
  // Post-package repair
  // Each fuse is one-shot: a fused bank refuses a second repair activate.
  rrr_ppr_t ppr_state, ppr_state_next;
  logic [24:0] ppr_tmr_reg, ppr_tmr_next;
  logic [2:0] ppr_bank_reg, ppr_bank_next;
  logic [7:0] fused_reg, fused_next;
  logic ppr_en_reg, ppr_en_next;

  always_comb begin
    ppr_state_next = ppr_state;
    ppr_tmr_next = ppr_tmr_reg;
    ppr_bank_next = ppr_bank_reg;
    fused_next = fused_reg;
    ppr_en_next = ppr_en_reg;
    flag_set = '0;
    case (ppr_state)
      PPR_IDLE: begin
        if (mrw_ppr && cmd_data[REPAIR_EN_BIT] && support != 8'h00) begin
          ppr_state_next = PPR_ARMING;
          ppr_en_next = 1'b1;
          ppr_tmr_next = 25'(MRD_CYC - 1);
        end
      end
      PPR_ARMING: begin
        if (ppr_tmr_reg == 25'h0) begin
          ppr_state_next = PPR_ARMED;
        end else begin
          ppr_tmr_next = ppr_tmr_reg - 25'h1;
        end
      end
      PPR_ARMED: begin
        if (is_act && !fused_reg[cmd_bank]) begin
          ppr_state_next = PPR_PROGRAM;
          ppr_bank_next = cmd_bank;
          ppr_tmr_next = 25'(PGM_CYCLES - 1);
        end
      end
      PPR_PROGRAM: begin
        if (ppr_tmr_reg != 25'h0) begin
          ppr_tmr_next = ppr_tmr_reg - 25'h1;
        end
        if (is_pre && ppr_tmr_reg == 25'h0) begin
          fused_next[ppr_bank_reg] = 1'b1;
          ppr_state_next = PPR_RECOG;
          ppr_tmr_next = 25'(EXIT_CYC - 1);
        end else if (is_pre) begin
          flag_set[1] = 1'b1;
          ppr_state_next = PPR_ARMED;
        end else if (any_cmd) begin
          flag_set[0] = 1'b1;
        end
      end
      PPR_RECOG: begin
        if (ppr_tmr_reg == 25'h0) begin
          ppr_state_next = PPR_READY;
        end else begin
          ppr_tmr_next = ppr_tmr_reg - 25'h1;
        end
      end
      PPR_READY: ppr_state_next = PPR_READY;
      default: ppr_state_next = PPR_IDLE;
    endcase
    if (mrw_ppr && !cmd_data[REPAIR_EN_BIT]) begin
      ppr_state_next = PPR_IDLE;
      ppr_en_next = 1'b0;
    end
    flag_set[2] = trr_clr && (trr_state != TRR_IDLE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ppr_state <= PPR_IDLE;
      ppr_tmr_reg <= 25'h0;
      ppr_bank_reg <= 3'h0;
      fused_reg <= 8'h00;
      ppr_en_reg <= 1'b0;
    end else begin
      ppr_state <= ppr_state_next;
      ppr_tmr_reg <= ppr_tmr_next;
      ppr_bank_reg <= ppr_bank_next;
      fused_reg <= fused_next;
      ppr_en_reg <= ppr_en_next;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_data_reg;
  wire logic take = hsel && hready && htrans[1];
  wire logic wr_cfg = wr_pend_reg && (wr_addr_reg == ADDR_CONFIG);
  wire logic wr_flags = wr_pend_reg && (wr_addr_reg == ADDR_FLAGS);
  wire logic [31:0] mode_view = {24'h0, trr_en_reg, trr_bank_reg, cfg_reg[3:0]};
  wire logic [31:0] state_view = {6'h0, ppr_en_reg, trr_en_reg, fused_reg, 5'h0, ppr_state,
    pre_cnt_reg, act_cnt_reg, 2'h0, trr_state};
  wire logic [31:0] rd_mux =
    (haddr[7:0] == ADDR_REFRESH_REPAIR) ? mode_view :
    (haddr[7:0] == ADDR_STATUS_REPAIR) ? {27'h0, ppr_en_reg, 4'h0} :
    (haddr[7:0] == ADDR_REPAIR_SUPPORT) ? {24'h0, support} :
    (haddr[7:0] == ADDR_CONFIG) ? {16'h0, cfg_reg} :
    (haddr[7:0] == ADDR_STATE) ? state_view :
    (haddr[7:0] == ADDR_FLAGS) ? {29'h0, flags_reg} : 32'h0;
  // Set wins over a simultaneous write-one-to-clear
  assign flags_next = (flags_reg & ~(wr_flags ? hwdata[FLAG_W-1:0] : '0)) | flag_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_data_reg <= 32'h0;
      cfg_reg <= CONFIG_RESET;
      flags_reg <= '0;
    end else begin
      wr_pend_reg <= take && hwrite;
      wr_addr_reg <= haddr[7:0];
      rd_data_reg <= (take && !hwrite && haddr[31:8] == 24'h0) ? rd_mux : 32'h0;
      cfg_reg <= wr_cfg ? hwdata[15:0] : cfg_reg;
      flags_reg <= flags_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_data_reg;
  assign trr_active = trr_en_reg;
  assign trr_bank = trr_bank_reg;
  assign repair_programming = (ppr_state == PPR_PROGRAM);
  assign fused_banks = fused_reg;

  // ==========================================================
  // Checks
  localparam int CHK_DONE_WAIT = TRP_CYC + MRD_CYC;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_unlim_ignore: assert property (trr_state == TRR_IDLE && trr_set && unlim_ignore |=> !trr_en_reg)
    else $error("Enable taken while unlimited and ignored");
  chk_entry_bank: assert property (trr_state == TRR_IDLE && trr_set && !unlim_ignore && !trr_clr
    |=> trr_state == TRR_ENTRY && trr_en_reg && trr_bank_reg == $past(cmd_data[6:4]))
    else $error("Entry write did not latch bank");
  chk_self_clear: assert property ($rose(trr_state == TRR_DONE) && !trr_clr |->
    (trr_en_reg && trr_state == TRR_DONE) [*1] ##CHK_DONE_WAIT (trr_state == TRR_IDLE || $past(trr_clr)))
    else $error("Self clear timing wrong");
  chk_exit_bank: assert property (trr_clr |=> !trr_en_reg && trr_state == TRR_IDLE && $stable(trr_bank_reg))
    else $error("Exit write mishandled");
  chk_pre_count: assert property (trr_state == TRR_ACTIVE && pre_counts && !trr_clr
    |=> pre_cnt_reg == $past(pre_cnt_reg) + 2'h1)
    else $error("Precharge not counted");
  chk_done_ops: assert property ($rose(trr_state == TRR_DONE) |-> act_cnt_reg == 2'h3 && pre_cnt_reg == 2'h3)
    else $error("Completed without three pairs");
  chk_fuse_once: assert property (ppr_state == PPR_ARMED && is_act && fused_reg[cmd_bank]
    |=> ppr_state != PPR_PROGRAM)
    else $error("Second repair on fused bank");
  chk_fuse_sticky: assert property (($past(fused_reg) & ~fused_reg) == 8'h00)
    else $error("Fuse reverted");

  cov_trr_full: cover property (trr_state == TRR_DONE ##CHK_DONE_WAIT trr_state == TRR_IDLE);
  cov_trr_abort: cover property (trr_state == TRR_ACTIVE && trr_clr);
  cov_fuse: cover property (ppr_state == PPR_PROGRAM ##1 ppr_state == PPR_RECOG);
endmodule : rrr_maint
`default_nettype wire

// ### hw/rrr_pkg.sv
/*
  Shared constants for the row refresh and repair block: register map,
  mode register fields, command codes, state codes and timing counts.
  Assumes a 20 MHz register clock; all cycle counts derive from that period.
*/
package rrr_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MODE_WRITE_DELAY_NS = 14;
  localparam int unsigned PRECHARGE_TIME_NS = 18;
  localparam int unsigned FUSE_PROGRAM_TIME_MS = 1000;
  localparam int unsigned FUSE_EXIT_TIME_NS = 15;
  // Least times round up
  localparam int unsigned MRD_CYC = (MODE_WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRP_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PGM_CYC = (FUSE_PROGRAM_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXIT_CYC = (FUSE_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRR_OPS = 3;
  // ==========================================================
  // Bus register byte offsets
  localparam logic [7:0] ADDR_REFRESH_REPAIR = 8'h00;
  localparam logic [7:0] ADDR_STATUS_REPAIR = 8'h04;
  localparam logic [7:0] ADDR_REPAIR_SUPPORT = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  // ==========================================================
  // Mode register addresses and fields
  localparam logic [5:0] MA_REFRESH_REPAIR = 6'h18;
  localparam logic [5:0] MA_STATUS_REPAIR = 6'h04;
  localparam int unsigned TRR_EN_BIT = 7;
  localparam int unsigned TRR_BANK_LSB = 4;
  localparam int unsigned REPAIR_EN_BIT = 4;
  localparam logic [2:0] LIMIT_UNLIMITED = 3'h0;
  // Config layout: [2:0] limit, [3] unlimited, [4] ignore enable when unlimited, [15:8] support
  localparam int unsigned CFG_UNLIM_BIT = 3;
  localparam int unsigned CFG_IGNORE_BIT = 4;
  localparam int unsigned CFG_SUPPORT_LSB = 8;
  localparam logic [15:0] CONFIG_RESET = 16'h0104;
  // Flags: [0] command while fusing, [1] early precharge, [2] refresh sequence aborted
  localparam int unsigned FLAG_W = 3;
  // ==========================================================
  // Commands and states
  typedef enum logic [2:0] {
    CMD_DES = 3'h0, CMD_ACT = 3'h1, CMD_PRE = 3'h2, CMD_REF = 3'h3,
    CMD_SRE = 3'h4, CMD_MRW = 3'h5, CMD_OTHER = 3'h6
  } rrr_cmd_t;
  typedef enum logic [1:0] {
    TRR_IDLE = 2'h0, TRR_ENTRY = 2'h1, TRR_ACTIVE = 2'h2, TRR_DONE = 2'h3
  } rrr_trr_t;
  typedef enum logic [2:0] {
    PPR_IDLE = 3'h0, PPR_ARMING = 3'h1, PPR_ARMED = 3'h2,
    PPR_PROGRAM = 3'h3, PPR_RECOG = 3'h4, PPR_READY = 3'h5
  } rrr_ppr_t;
endpackage : rrr_pkg

// ### verif/rrr_ctrl_model.sv
/*
  Behavioural memory controller driving the decoded DRAM command bus.
  Assumes its tasks are called by the bench right after a rising hclk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rrr_ctrl_model #(
  // Row-active time in cycles, rounded up; arbitrary default
  parameter int unsigned RAS_CYC = 2
) (
  input wire logic hclk,
  output logic cmd_valid,
  output rrr_pkg::rrr_cmd_t cmd_op,
  output logic [2:0] cmd_bank,
  output logic cmd_all,
  output logic [5:0] cmd_ma,
  output logic [7:0] cmd_data
);
  import rrr_pkg::*;
  // ==========================================================
  // Idle bus
  initial begin
    cmd_valid = 1'b0;
    cmd_op = CMD_DES;
    cmd_bank = 3'h0;
    cmd_all = 1'b0;
    cmd_ma = 6'h00;
    cmd_data = 8'h00;
  end
  // ==========================================================
  // One command per call; released fields flip so a stale value never looks valid
  task automatic issue(input rrr_cmd_t op, input logic [2:0] bank, input logic all, input logic [5:0] ma,
                       input logic [7:0] data);
    @(posedge hclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_bank <= bank;
    cmd_all <= all;
    cmd_ma <= ma;
    cmd_data <= data;
    @(posedge hclk);
    // The idle cycle after each command covers the one-cycle mode-write delay
    cmd_valid <= 1'b0;
    cmd_op <= CMD_DES;
    cmd_bank <= ~bank;
    cmd_all <= ~all;
    cmd_ma <= ~ma;
    cmd_data <= ~data;
  endtask : issue
  // Whole operand written at once, so bits other than enable and bank stay as given
  task automatic mrw(input logic [5:0] ma, input logic [7:0] data);
    issue(CMD_MRW, 3'h0, 1'b0, ma, data);
  endtask : mrw
  // Activate then precharge of the hammered row's bank; one hammered row per run
  // keeps a victim within two targets, and no refresh is sent in between
  task automatic trr_round(input logic [2:0] bank, input logic all, input logic first);
    issue(CMD_ACT, bank, 1'b0, 6'h00, 8'h00);
    repeat (first ? (3 * RAS_CYC + 1) / 2 : RAS_CYC) @(posedge hclk);
    // A precharge-all carries a different bank field, which must not matter
    issue(CMD_PRE, all ? ~bank : bank, all, 6'h00, 8'h00);
  endtask : trr_round
  // Row-active hold before the closing precharge
  task automatic row_hold();
    repeat (RAS_CYC) @(posedge hclk);
  endtask : row_hold
endmodule : rrr_ctrl_model
`default_nettype wire

// ### verif/test_row_refresh_and_repair_modes.sv
/*
  Self-checking bench for the row refresh and repair sequencer.
  Assumes the register slave answers with hreadyout and a one-cycle data phase.
*/
`timescale 1ns/100ps
`default_nettype none
module test_row_refresh_and_repair_modes;
  import rrr_pkg::*;
  localparam int unsigned PGM_SIM = 20;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, trr_active, repair_programming;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, trr_bank;
  logic [7:0] fused_banks;
  logic cmd_valid, cmd_all;
  rrr_cmd_t cmd_op;
  logic [2:0] cmd_bank;
  logic [5:0] cmd_ma;
  logic [7:0] cmd_data;
  int num_errors, checks_done, cycles;
  // ==========================================================
  // Instances
  rrr_maint #(.PGM_CYCLES(PGM_SIM)) u_rrr_maint (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_bank(cmd_bank), .cmd_all(cmd_all), .cmd_ma(cmd_ma), .cmd_data(cmd_data), .trr_active(trr_active),
    .trr_bank(trr_bank), .repair_programming(repair_programming), .fused_banks(fused_banks));
  rrr_ctrl_model u_rrr_ctrl_model (.hclk(hclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_bank(cmd_bank),
    .cmd_all(cmd_all), .cmd_ma(cmd_ma), .cmd_data(cmd_data));
  // ==========================================================
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      num_errors = num_errors + 1;
    end
  endtask : chk
  // Single AHB-Lite word transfer; read data taken at the edge ending the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    ahb(1'b0, a, 32'h00000000);
    chk(name, exp, rd);
  endtask : rd_chk
  task automatic test_end(input string name);
    $display("Test %s finished", name);
  endtask : test_end
  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  // ==========================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (5) @(posedge hclk);
    chk("reset outputs", 32'h0, {18'h0, trr_active, trr_bank, repair_programming, fused_banks, hresp});
    hresetn <= 1'b1;
    rd_chk(ADDR_CONFIG, 32'h00000104, "config reset");
    rd_chk(ADDR_REPAIR_SUPPORT, 32'h00000001, "support");
    ahb(1'b1, ADDR_REPAIR_SUPPORT, 32'hffffffff);
    rd_chk(ADDR_REPAIR_SUPPORT, 32'h00000001, "support read only");
    rd_chk(8'h20, 32'h00000000, "unmapped");
    test_end("reset");
    // Targeted refresh with a stray precharge, a refused re-entry and a precharge-all
    u_rrr_ctrl_model.mrw(MA_REFRESH_REPAIR, 8'hd0);
    #1 chk("trr enable", 32'h1, {31'h0, trr_active});
    chk("trr bank", 32'h5, {29'h0, trr_bank});
    u_rrr_ctrl_model.issue(CMD_PRE, 3'h5, 1'b0, 6'h00, 8'h00);
    u_rrr_ctrl_model.mrw(MA_REFRESH_REPAIR, 8'ha0);
    #1 chk("trr bank kept", 32'h5, {29'h0, trr_bank});
    u_rrr_ctrl_model.trr_round(3'h5, 1'b0, 1'b1);
    u_rrr_ctrl_model.trr_round(3'h5, 1'b1, 1'b0);
    u_rrr_ctrl_model.issue(CMD_ACT, 3'h5, 1'b0, 6'h00, 8'h00);
    #1 chk("trr not done early", 32'h1, {31'h0, trr_active});
    u_rrr_ctrl_model.row_hold();
    u_rrr_ctrl_model.issue(CMD_PRE, 3'h5, 1'b0, 6'h00, 8'h00);
    @(posedge hclk);
    #1 chk("trr hold", 32'h1, {31'h0, trr_active});
    @(posedge hclk);
    #1 chk("trr self clear", 32'h0, {31'h0, trr_active});
    u_rrr_ctrl_model.mrw(MA_REFRESH_REPAIR, 8'h00);
    #1 chk("exit bank ignored", 32'h5, {29'h0, trr_bank});
    test_end("targeted refresh");
    // Interrupted sequence, then the clearing precharges
    u_rrr_ctrl_model.mrw(MA_REFRESH_REPAIR, 8'h90);
    u_rrr_ctrl_model.issue(CMD_ACT, 3'h1, 1'b0, 6'h00, 8'h00);
    u_rrr_ctrl_model.mrw(MA_REFRESH_REPAIR, 8'h00);
    #1 chk("trr abort", 32'h0, {31'h0, trr_active});
    for (int i = 0; i < 3; i++) begin
      u_rrr_ctrl_model.issue(CMD_PRE, 3'h1, 1'b0, 6'h00, 8'h00);
    end
    rd_chk(ADDR_FLAGS, 32'h00000004, "abort flag");
    ahb(1'b1, ADDR_FLAGS, 32'h00000007);
    rd_chk(ADDR_FLAGS, 32'h00000000, "flags cleared");
    test_end("abort");
    // Unlimited tolerance with the ignore choice set
    ahb(1'b1, ADDR_CONFIG, 32'h00000118);
    rd_chk(ADDR_CONFIG, 32'h00000118, "config write");
    u_rrr_ctrl_model.mrw(MA_REFRESH_REPAIR, 8'h80);
    #1 chk("unlimited ignores enable", 32'h0, {31'h0, trr_active});
    ahb(1'b1, ADDR_CONFIG, 32'h00000104);
    test_end("unlimited");
    // Repair: early precharge, stray refresh, then a full program of bank 3
    u_rrr_ctrl_model.mrw(MA_STATUS_REPAIR, 8'h10);
    rd_chk(ADDR_STATUS_REPAIR, 32'h00000010, "repair enable");
    u_rrr_ctrl_model.issue(CMD_ACT, 3'h3, 1'b0, 6'h00, 8'h00);
    #1 chk("programming", 32'h1, {31'h0, repair_programming});
    u_rrr_ctrl_model.issue(CMD_PRE, 3'h3, 1'b0, 6'h00, 8'h00);
    #1 chk("early pre", 32'h0, {23'h0, repair_programming, fused_banks});
    u_rrr_ctrl_model.issue(CMD_ACT, 3'h3, 1'b0, 6'h00, 8'h00);
    u_rrr_ctrl_model.issue(CMD_REF, 3'h0, 1'b1, 6'h00, 8'h00);
    repeat (PGM_SIM) @(posedge hclk);
    #1 chk("still programming", 32'h1, {31'h0, repair_programming});
    u_rrr_ctrl_model.issue(CMD_PRE, 3'h3, 1'b0, 6'h00, 8'h00);
    @(posedge hclk);
    #1 chk("fused bank", 32'h08, {23'h0, repair_programming, fused_banks});
    rd_chk(ADDR_FLAGS, 32'h00000003, "repair flags");
    u_rrr_ctrl_model.mrw(MA_STATUS_REPAIR, 8'h00);
    rd_chk(ADDR_STATUS_REPAIR, 32'h00000000, "repair exit");
    u_rrr_ctrl_model.mrw(MA_STATUS_REPAIR, 8'h10);
    rd_chk(ADDR_STATUS_REPAIR, 32'h00000010, "rearm");
    u_rrr_ctrl_model.issue(CMD_ACT, 3'h3, 1'b0, 6'h00, 8'h00);
    #1 chk("fused bank refused", 32'h0, {31'h0, repair_programming});
    u_rrr_ctrl_model.mrw(MA_STATUS_REPAIR, 8'h00);
    // Repair ends in a device reset; the flags left set must clear
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADDR_FLAGS, 32'h00000000, "flags after reset");
    test_end("repair");
    // Repair refused without support
    ahb(1'b1, ADDR_CONFIG, 32'h00000004);
    u_rrr_ctrl_model.mrw(MA_STATUS_REPAIR, 8'h10);
    rd_chk(ADDR_STATUS_REPAIR, 32'h00000000, "no support");
    ahb(1'b1, ADDR_CONFIG, 32'h00000104);
    test_end("no support");
    test_done();
  end
endmodule : test_row_refresh_and_repair_modes
`default_nettype wire
